// file: logic/tcr_map.svh
`ifndef TCR_MAP_SVH
`define TCR_MAP_SVH
`define TCR_OP0_TRACE     2'h2
`define TCR_OP1_TRACE     3'h1
`define TCR_CRN_IDR7      4'h0
`define TCR_CRM_IDR7      4'hf
`define TCR_OP2_IDR7      3'h7
`define TCR_CRN_DEVCFG    4'h7
`define TCR_CRM_DEVCFG    4'h2
`define TCR_OP2_DEVCFG    3'h7
`define TCR_CRN_CLAIM     4'h7
`define TCR_CRM_CLAIMSET  4'h8
`define TCR_OP2_CLAIMSET  3'h6
`define TCR_CRM_CLAIMCLR  4'h9
`define TCR_OP2_CLAIMCLR  3'h6
`define TCR_SYNDROME_EC   6'h18
`define TCR_CLAIM_BITS    4
`define TCR_CLAIM_RESET   4'h0
`define TCR_DEVCFG_VALUE  64'h0
`define TCR_IDR7_VALUE    64'h0
`endif

// file: logic/tcr_pkg.sv
package tcr_pkg;
   typedef enum logic [1:0] {
      TCR_EL0,
      TCR_EL1,
      TCR_EL2,
      TCR_EL3
   } tcr_level_e;
   typedef enum logic [2:0] {
      TCR_OK,
      TCR_UNDEF,
      TCR_TRAP_EL1,
      TCR_TRAP_EL2,
      TCR_TRAP_EL3
   } tcr_outcome_e;
   typedef enum logic [2:0] {
      TCR_REG_NONE,
      TCR_REG_IDR7,
      TCR_REG_DEVCFG,
      TCR_REG_CLAIMSET,
      TCR_REG_CLAIMCLR
   } tcr_reg_e;
endpackage

// file: logic/tcr_decode.sv
`timescale 1ns/1ns
`default_nettype none
`include "tcr_map.svh"
module tcr_decode (
   input  wire logic [1:0] i_op0,
   input  wire logic [2:0] i_op1,
   input  wire logic [3:0] i_crn,
   input  wire logic [3:0] i_crm,
   input  wire logic [2:0] i_op2,
   input  wire logic       i_write,
   output var tcr_pkg::tcr_reg_e o_reg
);
   logic base;
   always_comb begin
      base  = (i_op0 == `TCR_OP0_TRACE) && (i_op1 == `TCR_OP1_TRACE);
      o_reg = tcr_pkg::TCR_REG_NONE;
      if (base && !i_write && i_crn == `TCR_CRN_IDR7 && i_crm == `TCR_CRM_IDR7
          && i_op2 == `TCR_OP2_IDR7) begin
         o_reg = tcr_pkg::TCR_REG_IDR7;
      end
      if (base && !i_write && i_crn == `TCR_CRN_DEVCFG && i_crm == `TCR_CRM_DEVCFG
          && i_op2 == `TCR_OP2_DEVCFG) begin
         o_reg = tcr_pkg::TCR_REG_DEVCFG;
      end
      if (base && i_crn == `TCR_CRN_CLAIM && i_crm == `TCR_CRM_CLAIMSET
          && i_op2 == `TCR_OP2_CLAIMSET) begin
         o_reg = tcr_pkg::TCR_REG_CLAIMSET;
      end
      if (base && i_crn == `TCR_CRN_CLAIM && i_crm == `TCR_CRM_CLAIMCLR
          && i_op2 == `TCR_OP2_CLAIMCLR) begin
         o_reg = tcr_pkg::TCR_REG_CLAIMCLR;
      end
   end
endmodule
`default_nettype wire

// file: logic/tcr_access_check.sv
`timescale 1ns/1ns
`default_nettype none
module tcr_access_check (
   input  wire tcr_pkg::tcr_level_e i_current_exception_level,
   input  wire logic                i_halted,
   input  wire logic                i_secure_debug_disabled,
   input  wire logic                i_level_one_trace_access_trap,
   input  wire logic                i_level_two_trace_access_trap,
   input  wire logic                i_level_three_trace_access_trap,
   input  wire logic                i_level_two_enabled,
   input  wire logic                i_fine_grain_trap_enable,
   input  wire logic                i_fine_grain_hit,
   output var tcr_pkg::tcr_outcome_e o_outcome
);
   logic hsd;
   always_comb begin
      hsd       = i_halted && i_secure_debug_disabled;
      o_outcome = tcr_pkg::TCR_OK;
      unique case (i_current_exception_level)
         tcr_pkg::TCR_EL0: o_outcome = tcr_pkg::TCR_UNDEF;
         tcr_pkg::TCR_EL1: begin
            if (hsd && i_level_three_trace_access_trap) o_outcome = tcr_pkg::TCR_UNDEF;
            else if (i_level_one_trace_access_trap) o_outcome = tcr_pkg::TCR_TRAP_EL1;
            else if (i_level_two_enabled && i_level_two_trace_access_trap)
               o_outcome = tcr_pkg::TCR_TRAP_EL2;
            else if (i_level_two_enabled && i_fine_grain_trap_enable && i_fine_grain_hit)
               o_outcome = tcr_pkg::TCR_TRAP_EL2;
            else if (i_level_three_trace_access_trap) o_outcome = tcr_pkg::TCR_TRAP_EL3;
         end
         tcr_pkg::TCR_EL2: begin
            if (hsd && i_level_three_trace_access_trap) o_outcome = tcr_pkg::TCR_UNDEF;
            else if (i_level_two_trace_access_trap) o_outcome = tcr_pkg::TCR_TRAP_EL2;
            else if (i_level_three_trace_access_trap) o_outcome = tcr_pkg::TCR_TRAP_EL3;
         end
         tcr_pkg::TCR_EL3: begin
            if (i_level_three_trace_access_trap) o_outcome = tcr_pkg::TCR_TRAP_EL3;
         end
      endcase
   end
endmodule
`default_nettype wire

// file: logic/tcr_regs.sv
`timescale 1ns/1ns
`default_nettype none
`include "tcr_map.svh"
module tcr_regs #(
   parameter int CLAIM_BITS = `TCR_CLAIM_BITS
) (
   input  wire logic                i_clock,
   input  wire logic                i_sys_rst,
   input  wire logic                i_valid,
   input  wire logic                i_write,
   input  wire logic [1:0]          i_op0,
   input  wire logic [2:0]          i_op1,
   input  wire logic [3:0]          i_crn,
   input  wire logic [3:0]          i_crm,
   input  wire logic [2:0]          i_op2,
   input  wire logic [63:0]         i_wdata,
   input  wire tcr_pkg::tcr_level_e i_current_exception_level,
   input  wire logic                i_halted,
   input  wire logic                i_secure_debug_disabled,
   input  wire logic                i_level_one_trace_access_trap,
   input  wire logic                i_level_two_trace_access_trap,
   input  wire logic                i_level_three_trace_access_trap,
   input  wire logic                i_level_two_enabled,
   input  wire logic                i_fine_grain_trap_enable,
   input  wire logic                i_fine_grain_id_read_trap,
   input  wire logic                i_fine_grain_claim_read_trap,
   input  wire logic                i_fine_grain_claim_write_trap,
   input  wire logic                i_ext_valid,
   input  wire logic                i_ext_write,
   input  wire logic                i_ext_sel_clr,
   input  wire logic                i_ext_sel_devcfg,
   input  wire logic [31:0]         i_ext_wdata,
   output logic                     o_done,
   output logic [63:0]              o_rdata,
   output logic                     o_undefined,
   output logic                     o_trap,
   output logic [1:0]               o_trap_level,
   output logic [5:0]               o_syndrome_class,
   output logic                     o_no_register,
   output logic [31:0]              o_ext_rdata,
   output logic [CLAIM_BITS-1:0]    o_claim_tags
);
   typedef struct packed {
      logic [CLAIM_BITS-1:0] claim;
      logic                  done;
      logic [63:0]           rdata;
      logic                  undefined;
      logic                  trap;
      logic [1:0]            trap_level;
      logic                  no_register;
      logic [31:0]           ext_rdata;
   } tcr_state_s;

   tcr_state_s            state;
   tcr_state_s            next_state;
   tcr_pkg::tcr_reg_e     reg_sel;
   tcr_pkg::tcr_outcome_e outcome;
   logic                  fg_hit;
   logic [CLAIM_BITS-1:0] impl_mask;
   logic [CLAIM_BITS-1:0] set_bits;
   logic [CLAIM_BITS-1:0] clr_bits;

   tcr_decode u_decode (
      .i_op0   (i_op0),
      .i_op1   (i_op1),
      .i_crn   (i_crn),
      .i_crm   (i_crm),
      .i_op2   (i_op2),
      .i_write (i_write),
      .o_reg   (reg_sel)
   );

   always_comb begin
      fg_hit = 1'b0;
      unique case (reg_sel)
         tcr_pkg::TCR_REG_IDR7, tcr_pkg::TCR_REG_DEVCFG: fg_hit = i_fine_grain_id_read_trap;
         tcr_pkg::TCR_REG_CLAIMSET, tcr_pkg::TCR_REG_CLAIMCLR:
            fg_hit = i_write ? i_fine_grain_claim_write_trap : i_fine_grain_claim_read_trap;
         default: fg_hit = 1'b0;
      endcase
   end

   tcr_access_check u_check (
      .i_current_exception_level       (i_current_exception_level),
      .i_halted                        (i_halted),
      .i_secure_debug_disabled         (i_secure_debug_disabled),
      .i_level_one_trace_access_trap   (i_level_one_trace_access_trap),
      .i_level_two_trace_access_trap   (i_level_two_trace_access_trap),
      .i_level_three_trace_access_trap (i_level_three_trace_access_trap),
      .i_level_two_enabled             (i_level_two_enabled),
      .i_fine_grain_trap_enable        (i_fine_grain_trap_enable),
      .i_fine_grain_hit                (fg_hit),
      .o_outcome                       (outcome)
   );

   assign impl_mask = {CLAIM_BITS{1'b1}};

   always_comb begin
      next_state             = state;
      next_state.done        = 1'b0;
      next_state.undefined   = 1'b0;
      next_state.trap        = 1'b0;
      next_state.no_register = 1'b0;
      set_bits               = '0;
      clr_bits               = '0;
      if (i_valid) begin
         next_state.done       = 1'b1;
         next_state.rdata      = 64'h0;
         next_state.trap_level = 2'h0;
         if (reg_sel == tcr_pkg::TCR_REG_NONE) begin
            next_state.no_register = 1'b1;
         end else begin
            unique case (outcome)
               tcr_pkg::TCR_OK: begin
                  unique case (reg_sel)
                     tcr_pkg::TCR_REG_IDR7: next_state.rdata = `TCR_IDR7_VALUE;
                     tcr_pkg::TCR_REG_DEVCFG: next_state.rdata = `TCR_DEVCFG_VALUE;
                     tcr_pkg::TCR_REG_CLAIMSET: begin
                        next_state.rdata = {{(64 - CLAIM_BITS){1'b0}}, impl_mask};
                        if (i_write) set_bits = i_wdata[CLAIM_BITS-1:0];
                     end
                     tcr_pkg::TCR_REG_CLAIMCLR: begin
                        next_state.rdata = {{(64 - CLAIM_BITS){1'b0}}, state.claim};
                        if (i_write) clr_bits = i_wdata[CLAIM_BITS-1:0];
                     end
                     default: next_state.rdata = 64'h0;
                  endcase
               end
               tcr_pkg::TCR_UNDEF: next_state.undefined = 1'b1;
               tcr_pkg::TCR_TRAP_EL1: begin
                  next_state.trap       = 1'b1;
                  next_state.trap_level = 2'h1;
               end
               tcr_pkg::TCR_TRAP_EL2: begin
                  next_state.trap       = 1'b1;
                  next_state.trap_level = 2'h2;
               end
               tcr_pkg::TCR_TRAP_EL3: begin
                  next_state.trap       = 1'b1;
                  next_state.trap_level = 2'h3;
               end
            endcase
         end
      end
      if (i_ext_valid && i_ext_write && !i_ext_sel_devcfg) begin
         if (i_ext_sel_clr) clr_bits = clr_bits | i_ext_wdata[CLAIM_BITS-1:0];
         else set_bits = set_bits | i_ext_wdata[CLAIM_BITS-1:0];
      end
      // Set wins when both land together
      next_state.claim = ((state.claim & ~clr_bits) | set_bits) & impl_mask;
      if (i_ext_sel_devcfg) next_state.ext_rdata = 32'(`TCR_DEVCFG_VALUE);
      else if (i_ext_sel_clr) next_state.ext_rdata = {{(32 - CLAIM_BITS){1'b0}}, state.claim};
      else next_state.ext_rdata = {{(32 - CLAIM_BITS){1'b0}}, impl_mask};
      if (!i_ext_valid) next_state.ext_rdata = 32'h0;
   end

   always_ff @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         state       <= '0;
         state.claim <= CLAIM_BITS'(`TCR_CLAIM_RESET);
      end else begin
         state <= next_state;
      end
   end

   assign o_done           = state.done;
   assign o_rdata          = state.rdata;
   assign o_undefined      = state.undefined;
   assign o_trap           = state.trap;
   assign o_trap_level     = state.trap_level;
   assign o_syndrome_class = state.trap ? `TCR_SYNDROME_EC : 6'h0;
   assign o_no_register    = state.no_register;
   assign o_ext_rdata      = state.ext_rdata;
   assign o_claim_tags     = state.claim;
endmodule
`default_nettype wire

// file: dv/tcr_regs_chk.sv
`timescale 1ns/1ns
`default_nettype none
module tcr_regs_chk #(
   parameter int CLAIM_BITS = 4
) (
   input wire logic                  i_clock,
   input wire logic                  i_sys_rst,
   input wire logic                  i_valid,
   input wire logic                  i_write,
   input wire logic [1:0]            i_op0,
   input wire logic [2:0]            i_op1,
   input wire logic [3:0]            i_crn,
   input wire logic [3:0]            i_crm,
   input wire logic [2:0]            i_op2,
   input wire logic [63:0]           i_wdata,
   input wire tcr_pkg::tcr_level_e   i_current_exception_level,
   input wire logic                  i_halted,
   input wire logic                  i_secure_debug_disabled,
   input wire logic                  i_level_three_trace_access_trap,
   input wire logic                  i_ext_valid,
   input wire logic                  o_done,
   input wire logic                  o_undefined,
   input wire logic                  o_trap,
   input wire logic [1:0]            o_trap_level,
   input wire logic [5:0]            o_syndrome_class,
   input wire logic [31:0]           o_ext_rdata,
   input wire logic [CLAIM_BITS-1:0] o_claim_tags
);
   logic [CLAIM_BITS-1:0] want_tags;
   wire t3 = i_level_three_trace_access_trap;
   // External view left out so its clear cannot blur the set
   wire set_ok = i_valid && i_write && i_op0 == 2'h2 && i_op1 == 3'h1 && i_crn == 4'h7
      && i_crm == 4'h8 && i_op2 == 3'h6 && !t3 && !i_ext_valid
      && i_current_exception_level == tcr_pkg::TCR_EL3;
   always_ff @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         want_tags <= '0;
      end else begin
         want_tags <= o_claim_tags | i_wdata[CLAIM_BITS-1:0];
      end
   end
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_sys_rst);
   sequence s_req(tcr_pkg::tcr_level_e lv);
      i_valid && i_current_exception_level == lv;
   endsequence
   sequence s_undef;
      o_done && o_undefined && !o_trap;
   endsequence
   chk_done_after_req: assert property (i_valid |=> o_done)
      else $error("no completion after request");
   chk_no_stray_done: assert property (!i_valid |=> !o_done && !o_trap && !o_undefined)
      else $error("completion without request");
   chk_level0_undef: assert property (s_req(tcr_pkg::TCR_EL0) |=> s_undef)
      else $error("level zero access not undefined");
   chk_halt_undef_first: assert property (s_req(tcr_pkg::TCR_EL1) && i_halted
      && i_secure_debug_disabled && t3 |=> s_undef) else $error("halted access not undefined");
   chk_top_level_trap: assert property (s_req(tcr_pkg::TCR_EL3) && t3
      |=> o_trap && o_trap_level == 2'h3 && !o_undefined) else $error("level three trap missing");
   chk_trap_class: assert property (o_trap |-> o_syndrome_class == 6'h18)
      else $error("wrong syndrome class");
   chk_claim_set: assert property (set_ok |=> o_claim_tags == want_tags)
      else $error("claim set write wrong");
   chk_claims_hold: assert property (!i_valid && !i_ext_valid |=> $stable(o_claim_tags))
      else $error("claim bits moved while idle");
   chk_ext_idle_zero: assert property (!i_ext_valid |=> o_ext_rdata == 32'h0)
      else $error("external data without access");
endmodule
bind tcr_regs tcr_regs_chk #(.CLAIM_BITS(CLAIM_BITS)) tcr_regs_chk_i (
   .i_clock, .i_sys_rst, .i_valid, .i_write, .i_op0, .i_op1, .i_crn, .i_crm, .i_op2,
   .i_wdata, .i_current_exception_level, .i_halted, .i_secure_debug_disabled,
   .i_level_three_trace_access_trap, .i_ext_valid, .o_done, .o_undefined, .o_trap,
   .o_trap_level, .o_syndrome_class, .o_ext_rdata, .o_claim_tags
);
`default_nettype wire

// file: dv/tcr_core_model.sv
`timescale 1ns/1ns
`default_nettype none
module tcr_core_model (
   input  wire logic        i_clock,
   input  wire logic        i_sys_rst,
   input  wire logic        i_go,
   input  wire logic [28:0] i_cmd,
   output var logic         o_valid,
   output var logic [28:0]  o_cmd
);
   // Fields churn between instructions so idle values are never trusted
   always_ff @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_valid <= 1'b0;
         o_cmd   <= 29'h0;
      end else begin
         o_valid <= i_go;
         o_cmd   <= i_go ? i_cmd : ~o_cmd;
      end
   end
endmodule
`default_nettype wire

// file: dv/tcr_regs_tb.sv
`timescale 1ns/1ns
`default_nettype none
module tcr_regs_tb;
   localparam logic [15:0] E_ID = {2'h2, 3'h1, 4'h0, 4'hf, 3'h7};
   localparam logic [15:0] E_DEV = {2'h2, 3'h1, 4'h7, 4'h2, 3'h7};
   localparam logic [15:0] E_SET = {2'h2, 3'h1, 4'h7, 4'h8, 3'h6};
   localparam logic [15:0] E_CLR = {2'h2, 3'h1, 4'h7, 4'h9, 3'h6};
   logic        clock;
   logic        rst;
   logic        go;
   logic [28:0] cmd;
   logic        valid;
   logic [28:0] pc;
   logic [63:0] wdata;
   logic        ev;
   logic        ew;
   logic        eclr;
   logic        edev;
   logic [31:0] ewd;
   logic        done;
   logic        undef;
   logic        trap;
   logic        nreg;
   logic [1:0]  tlvl;
   logic [5:0]  syn;
   logic [63:0] rdata;
   logic [31:0] erd;
   logic [3:0]  tags;
   int          num_errors;
   int          checks;
   tcr_core_model tcr_core_model_i (.i_clock(clock), .i_sys_rst(rst), .i_go(go),
      .i_cmd(cmd), .o_valid(valid), .o_cmd(pc));
   tcr_regs tcr_regs_i (.i_clock(clock), .i_sys_rst(rst), .i_valid(valid),
      .i_write(pc[28]), .i_op0(pc[27:26]), .i_op1(pc[25:23]), .i_crn(pc[22:19]),
      .i_crm(pc[18:15]), .i_op2(pc[14:12]), .i_wdata(wdata),
      .i_current_exception_level(tcr_pkg::tcr_level_e'(pc[11:10])), .i_halted(pc[9]),
      .i_secure_debug_disabled(pc[8]), .i_level_one_trace_access_trap(pc[7]),
      .i_level_two_trace_access_trap(pc[6]), .i_level_three_trace_access_trap(pc[5]),
      .i_level_two_enabled(pc[4]), .i_fine_grain_trap_enable(pc[3]),
      .i_fine_grain_id_read_trap(pc[2]), .i_fine_grain_claim_read_trap(pc[1]),
      .i_fine_grain_claim_write_trap(pc[0]), .i_ext_valid(ev), .i_ext_write(ew),
      .i_ext_sel_clr(eclr), .i_ext_sel_devcfg(edev), .i_ext_wdata(ewd), .o_done(done),
      .o_rdata(rdata), .o_undefined(undef), .o_trap(trap), .o_trap_level(tlvl),
      .o_syndrome_class(syn), .o_no_register(nreg), .o_ext_rdata(erd), .o_claim_tags(tags));
   initial begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end
   task automatic chk(input string nm, input logic [63:0] ex, input logic [63:0] got);
      checks++;
      if (got !== ex) begin
         $display("BAD %s exp %h got %h", nm, ex, got);
         num_errors++;
      end
   endtask
   task automatic test_done;
      $display("errors %0d checks %0d", num_errors, checks);
      if (num_errors == 0 && checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // Bit 9..0 of ct: halted, sdd, trap1, trap2, trap3, el2, fgt, fgid, fgcr, fgcw
   task automatic req(input logic wr, input logic [15:0] enc, input logic [1:0] lv,
         input logic [9:0] ct, input logic [63:0] wd);
      int n;
      @(posedge clock);
      go    <= 1'b1;
      cmd   <= {wr, enc, lv, ct};
      wdata <= wd;
      @(posedge clock);
      go <= 1'b0;
      for (n = 0; n < 20 && done !== 1'b1; n++) begin
         @(posedge clock);
         #1;
      end
      if (done !== 1'b1) begin
         num_errors++;
         test_done();
      end
   endtask
   task automatic ext(input logic wr, input logic clr, input logic dev, input logic [31:0] wd);
      @(posedge clock);
      ev   <= 1'b1;
      ew   <= wr;
      eclr <= clr;
      edev <= dev;
      ewd  <= wd;
      @(posedge clock);
      ev <= 1'b0;
      #1;
   endtask
   task automatic acc(input logic [1:0] lv, input logic [9:0] ct, input logic [2:0] ex);
      req(1'b0, E_ID, lv, ct, 64'h0);
      chk("outcome", 64'(ex), 64'(undef ? 3'h4 : trap ? {1'b0, tlvl} : 3'h0));
      chk("class", (ex inside {3'h1, 3'h2, 3'h3}) ? 64'h18 : 64'h0, 64'(syn));
   endtask
   task automatic t_claims;
      // Agent announces use by setting claims; upper ones must be dropped
      req(1'b1, E_SET, 2'h3, 10'h0, 64'hffff_ffff_ffff_fff5);
      chk("tags set", 64'h5, 64'(tags));
      req(1'b1, E_SET, 2'h3, 10'h0, 64'h0);
      chk("tags zero write", 64'h5, 64'(tags));
      req(1'b0, E_SET, 2'h3, 10'h0, 64'h0);
      chk("set read", 64'hf, rdata);
      req(1'b0, E_CLR, 2'h3, 10'h0, 64'h0);
      chk("clear read", 64'h5, rdata);
      ext(1'b1, 1'b1, 1'b0, 32'h1);
      chk("ext clear", 64'h4, 64'(tags));
      ext(1'b0, 1'b0, 1'b0, 32'h0);
      chk("ext set read", 64'hf, 64'(erd));
      ext(1'b0, 1'b0, 1'b1, 32'h0);
      chk("ext devcfg", 64'h0, 64'(erd));
      req(1'b1, E_DEV, 2'h3, 10'h0, 64'hffff_ffff_ffff_ffff);
      chk("ro write", 64'h14, 64'({nreg, tags}));
      req(1'b1, E_ID, 2'h3, 10'h0, 64'hffff_ffff_ffff_ffff);
      chk("id write", 64'h14, 64'({nreg, tags}));
   endtask
   task automatic t_reset;
      // Held claims must not survive a reset in mid-run
      @(posedge clock);
      rst <= 1'b1;
      repeat (3) @(posedge clock);
      rst <= 1'b0;
      #1;
      chk("mid reset tags", 64'h0, 64'({done, tags}));
   endtask
   task automatic t_ids;
      req(1'b0, E_ID, 2'h3, 10'h0, 64'h0);
      chk("id read", 64'h0, {nreg, rdata[62:0]} | 64'(rdata[63]));
      req(1'b0, E_DEV, 2'h3, 10'h0, 64'h0);
      chk("devcfg read", 64'h0, {nreg, rdata[62:0]} | 64'(rdata[63]));
   endtask
   task automatic t_claim_traps;
      req(1'b1, E_SET, 2'h1, 10'b0000011001, 64'ha);
      chk("fg write trap", 64'h60, 64'({trap, tlvl, tags}));
      req(1'b0, E_CLR, 2'h1, 10'b0000011010, 64'h0);
      chk("fg read trap", 64'h6, 64'({trap, tlvl}));
      req(1'b0, E_SET, 2'h1, 10'b0000011001, 64'h0);
      chk("fg read pass", 64'hf, rdata);
      req(1'b1, E_SET, 2'h0, 10'h0, 64'h3);
      chk("level zero write", 64'h10, 64'({undef, tags}));
      req(1'b1, E_SET, 2'h3, 10'h0, 64'h3);
      chk("tags set two", 64'h3, 64'(tags));
      req(1'b1, E_CLR, 2'h3, 10'h0, 64'h1);
      chk("clear write", 64'h2, 64'(tags));
      ext(1'b1, 1'b0, 1'b0, 32'h8);
      chk("ext set", 64'ha, 64'(tags));
      // Core set and external clear land on one edge
      @(posedge clock);
      go    <= 1'b1;
      cmd   <= {1'b1, E_SET, 2'h3, 10'h0};
      wdata <= 64'h1;
      @(posedge clock);
      go   <= 1'b0;
      ev   <= 1'b1;
      ew   <= 1'b1;
      eclr <= 1'b1;
      edev <= 1'b0;
      ewd  <= 32'h3;
      @(posedge clock);
      ev <= 1'b0;
      #1;
      chk("set beats clear", 64'h19, 64'({done, tags}));
   endtask
   initial begin
      num_errors = 0;
      checks = 0;
      rst = 1'b1;
      {go, cmd, wdata, ev, ew, eclr, edev, ewd} = '0;
      repeat (10) @(posedge clock);
      rst <= 1'b0;
      #1;
      chk("reset tags", 64'h0, 64'(tags));
      t_claims();
      t_reset();
      t_ids();
      t_claim_traps();
      acc(2'h0, 10'h0, 3'h4);
      acc(2'h1, 10'b1110100000, 3'h4);
      acc(2'h1, 10'b0011000000, 3'h1);
      acc(2'h1, 10'b0001010000, 3'h2);
      acc(2'h1, 10'b0001000000, 3'h0);
      acc(2'h1, 10'b0000011100, 3'h2);
      acc(2'h2, 10'b0001100000, 3'h2);
      acc(2'h2, 10'b1000100000, 3'h3);
      acc(2'h3, 10'b0000100000, 3'h3);
      acc(2'h3, 10'h0, 3'h0);
      test_done();
   end
endmodule
`default_nettype wire
